// ---- bench/fx_line_peer.sv ----
`timescale 1ns/1ps
// Far end of the pair: loops our drive back, sends link pulses when muted, or sends the bench's NRZ bits
module fx_line_peer (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic loop_back,
  input  wire logic mute,
  input  wire logic plain,
  input  wire logic bit_in,
  input  wire logic tx_pos,
  input  wire logic tx_neg,
  output logic      rx_pos,
  output logic      rx_neg
);
  logic [10:0] lfsr_ff;
  logic [1:0]  lvl_ff;
  logic [7:0]  gap_ff;
  logic        nxt_s;

  // Same x^11 + x^9 + 1 sequence; plain mode skips it for bypass runs
  assign nxt_s = lfsr_ff[10] ^ lfsr_ff[8];

  // Each NRZI one steps the level 0,+,0,-; zeros hold it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lfsr_ff <= 11'h5a5;
      lvl_ff  <= 2'h0;
    end else begin
      lfsr_ff <= {lfsr_ff[9:0], nxt_s};
      if (bit_in ^ (nxt_s & ~plain)) lvl_ff <= lvl_ff + 2'h1;
    end
  end

  // Link pulse spacing; far too sparse to pass as a 100 Mb/s signal
  always_ff @(posedge ref_clk) begin
    if (reset) gap_ff <= 8'h00;
    else gap_ff <= gap_ff + 8'h01;
  end

  // Unless looping back, mute shows link pulses only, never a scrambled stream
  assign rx_pos = loop_back ? tx_pos : mute ? (gap_ff == 8'h00) : (lvl_ff == 2'h1);
  assign rx_neg = loop_back ? tx_neg : ~mute & (lvl_ff == 2'h3);
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module testbench import fx_pkg::*; ;
  localparam int LINK = 100;
  // Data code-groups for nibbles 0 to F
  localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  fx_txw_t     tx_word = '0;
  logic        tx_valid = 1'b0;
  logic        loop_back = 1'b1;
  logic        mute = 1'b0;
  logic        byp = 1'b0;
  logic        bit_in = 1'b1;
  logic [4:0]  straps = 5'h00;
  logic        tx_ready, tx_pos, tx_neg, rx_pos, rx_neg, stb, link, sd, sync;
  fx_mii_t     mii;
  logic [15:0] fcnt;
  int          error_cnt = 0;
  int          tests_run = 0;
  fx_mii_t     got_q[$];
  logic [10:0] obs;
  logic [31:0] hist;
  int          run;
  logic        pp, pn, nrz;

  fx_pcs #(.HOLD_CYC(200), .LINK_CYC(LINK)) uut (.ref_clk(ref_clk), .reset(reset),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pos_ff(tx_pos),
    .tx_neg_ff(tx_neg), .rx_pos(rx_pos), .rx_neg(rx_neg), .phy_address_straps(straps),
    .descrambler_bypass(byp), .rx_mii_ff(mii), .rx_stb_ff(stb), .link_up_ff(link),
    .sig_detect_ff(sd), .desc_sync_ff(sync), .false_carrier_event_counter(fcnt));
  fx_line_peer peer (.ref_clk(ref_clk), .reset(reset), .loop_back(loop_back), .mute(mute),
    .plain(byp), .bit_in(bit_in), .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_pos(rx_pos),
    .rx_neg(rx_neg));

  always #5 ref_clk = ~ref_clk;

  // Line watcher: level change is an NRZ one; descrambler trains on idle
  always @(posedge ref_clk) begin
    if (reset) begin
      run = 0;
      pp = 1'b0;
      pn = 1'b0;
    end else begin
      `CHK("both_phases", 1'b0, tx_pos & tx_neg)
      `CHK("level_jump", 1'b0, (pp & tx_neg) | (pn & tx_pos))
      nrz = {tx_pos, tx_neg} != {pp, pn};
      hist = {hist[30:0], nrz};
      run = (nrz ^ obs[10] ^ obs[8]) ? run + 1 : 0;
      obs = {obs[9:0], ~nrz};
      if (stb) got_q.push_back(mii);
      pp = tx_pos;
      pn = tx_neg;
    end
  end

  task print_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task do_reset(input logic [4:0] s, input logic lb, input logic bp, input logic mu);
    straps <= s;
    loop_back <= lb;
    byp <= bp;
    mute <= mu;
    reset <= 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    got_q.delete();
  endtask

  // One code-group onto the line, first bit first
  task grp(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) begin
      bit_in <= g[i];
      @(posedge ref_clk);
    end
  endtask

  task idles(input int n);
    repeat (n) grp(5'h1f);
  endtask

  // Holds the word until the FIFO takes it
  task push(input logic [3:0] n, input logic l);
    tx_word <= '{last: l, nib: n};
    tx_valid <= 1'b1;
    do @(posedge ref_clk); while (tx_ready !== 1'b1);
  endtask

  task chk_rx(input logic [3:0] ex[$], input logic exact);
    if (exact) `CHK("strobes", ex.size(), got_q.size())
    foreach (ex[i]) if (i < got_q.size())
      `CHK("nibble", {1'b1, 1'b0, 1'b1, ex[i]}, got_q[i])
    `CHK("frame_closed", 3'h0, {mii.dv, mii.er, mii.crs})
  endtask

  // Idle line pattern, seed choice and FIFO refusal while the link is down
  task t_seed_fifo;
    logic [31:0] h[3];
    foreach (h[k]) begin
      do_reset(k == 1 ? 5'h1c : {4'h1, k == 2}, 1'b0, 1'b0, 1'b1);
      repeat (150) @(posedge ref_clk);
      h[k] = hist;
      `CHK("idle_descrambled", 1'b1, run > 100)
    end
    `CHK("seed_by_straps", 1'b1, h[0] != h[1])
    `CHK("seed_ignores_bit0", h[0], h[2])
    for (int i = 0; i < 16; i++) begin
      tx_word <= '{last: 1'b0, nib: i[3:0]};
      tx_valid <= 1'b1;
      @(posedge ref_clk);
      `CHK("fifo_room", 1'b1, tx_ready)
    end
    repeat (2) @(posedge ref_clk);
    `CHK("fifo_full", 1'b0, tx_ready)
    tx_valid <= 1'b0;
  endtask

  // Own drive looped back: link timing, full frame, then link pulses only
  task t_loop_frame;
    logic [3:0] ex[$];
    int n;
    do_reset(5'h00, 1'b1, 1'b0, 1'b0);
    n = 0;
    while (sd !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (link !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("link_delay", 1'b1, n >= LINK - 1 && n <= LINK + 2)
    n = 0;
    while (sync !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    got_q.delete();
    ex = '{4'h5, 4'h5};
    push(4'h5, 1'b0);
    push(4'h5, 1'b0);
    for (int i = 0; i < 16; i++) begin
      push(i[3:0], i == 15);
      ex.push_back(i[3:0]);
    end
    tx_valid <= 1'b0;
    n = 0;
    while ((got_q.size() < 18 || mii.crs !== 1'b0) && n < 800) begin
      @(posedge ref_clk);
      n++;
    end
    chk_rx(ex, 1'b1);
    loop_back <= 1'b0;
    mute <= 1'b1;
    repeat (700) @(posedge ref_clk);
    `CHK("sd_on_pulses", 2'h0, {sd, link})
  endtask

  // Bench-made stream: frames, bad delimiters, hold timer, bypass
  task t_inject(input logic bp);
    logic [3:0] ex[$];
    do_reset(5'h00, 1'b0, bp, 1'b0);
    idles(130);
    `CHK("link_and_sync", 1'b1, link & (sync | bp))
    for (int e = 0; e < 2; e++) begin
      // Bypass skips the refresh idles and sends long frames, so sync expires
      if (!bp) idles(12);
      got_q.delete();
      ex = '{4'h5, 4'h5};
      grp(5'h18);
      grp(5'h11);
      for (int i = 0; i < (bp ? 32 : 16); i++) begin
        grp(CODE[i[3:0]]);
        ex.push_back(i[3:0]);
      end
      if (e == 0) begin
        grp(5'h0d);
        grp(5'h07);
      end
      idles(3);
      chk_rx(ex, 1'b1);
    end
    if (!bp) begin
      for (int b = 1; b <= 2; b++) begin
        // Twelve idles arm the hunt and reload the hold timer
        idles(12);
        got_q.delete();
        repeat (3) grp(5'h14);
        idles(4);
        `CHK("false_carrier", 16'(b), fcnt)
        `CHK("bad_groups", 1'b1, got_q.size() >= 3)
        foreach (got_q[i])
          `CHK("bad_nib", 6'h3e, {got_q[i].er, got_q[i].crs, got_q[i].nib})
        `CHK("bad_cleared", 2'h0, {mii.er, mii.crs})
      end
      idles(100);
      `CHK("sync_held", 1'b1, sync)
      grp(5'h18);
      grp(5'h11);
      repeat (60) grp(5'h14);
      `CHK("sync_lost", 1'b0, sync)
      idles(40);
      `CHK("sync_again", 1'b1, sync)
    end
  endtask

  initial begin
    t_seed_fifo;
    t_loop_frame;
    t_inject(1'b0);
    t_inject(1'b1);
    print_verdict;
  end

  // Hang guard, well past the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    print_verdict;
  end
endmodule

// ---- common/fx_cfg.svh ----
`ifndef FX_CFG_SVH
`define FX_CFG_SVH
// Notes on behaviour
// R1 - 11-bit closed-loop LFSR scrambles serial stream
// R2 - NRZ bit XOR LFSR output bit
// R3 - Seed taken from address straps bits 4:1
// R4 - Scrambled stream NRZI encoded before MLT-3
// R5 - Ones alternate between two drive streams
// R6 - Line output carries only MLT-3 levels
// R7 - Link pulses alone never raise signal detect
// R8 - Receive symbols are five bits wide
// R9 - Descrambler XORs local sequence into received bits
// R10 - Sync after twelve IDLE groups, all ones
// R11 - Hold timer 722 us, restarts on 58 idle bits
// R12 - Timer expiry drops sync, full restart
// R13 - J/K locks the five-bit group boundary
// R14 - Bypass feeds aligner from NRZI decoder
// R15 - J/K after IDLE delivered as 0101 0101
// R16 - Decode groups until T/R or two IDLEs
// R17 - Link up after 395 us signal detect
// R18 - IDLE to non-IDLE without J/K is bad delimiter
// R19 - Bad delimiter gives error, nibble 1110 per group
// R20 - Each bad delimiter bumps false carrier counter
// R21 - Two IDLEs end error and carrier
// R22 - Standard 4B5B code-group mapping
// R23 - Feedback polynomial x^11 + x^9 + 1
// R24 - NRZI toggles on one, decoder inverts
// R25 - MLT-3 level change decodes to one
`define FX_CG_I 5'h1f
`define FX_CG_J 5'h18
`define FX_CG_K 5'h11
`define FX_CG_T 5'h0d
`define FX_CG_R 5'h07
`define FX_CG_H 5'h04
`define FX_4B5B {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12, \
  5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e}
`define FX_JK 10'h311
`define FX_PRE_NIB 4'h5
`define FX_BAD_NIB 4'he
`define FX_SYNC_BITS 7'h3c
`define FX_HOLD_BITS 7'h3a
`define FX_IDLE_PRE 7'h0a
`define FX_HUNT_LAST 3'h6
`define FX_GRP_LAST 3'h4
`define FX_HOLD_US 722
`define FX_LINK_US 395
`define FX_CLK_MHZ 100
`define FX_SD_GAP 6'h20
`define FX_SD_RUN 9'h100
`define FX_SEED_FILL 7'h55
`define FX_LFSR_RST 11'h7ff
`define FX_SEED_AT 2'h2
`define FX_FIFO_DEPTH 16
`endif

// ---- common/fx_pkg.sv ----
package fx_pkg;
  typedef struct packed {
    logic       last;
    logic [3:0] nib;
  } fx_txw_t;
  typedef struct packed {
    logic       dv;
    logic       er;
    logic       crs;
    logic [3:0] nib;
  } fx_mii_t;
  typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_T, TX_R} fx_txst_t;
  typedef enum logic [2:0] {RX_IDLE, RX_HUNT, RX_PRE, RX_FRAME, RX_T, RX_BAD} fx_rxst_t;
endpackage

// ---- hw/fx_pcs.sv ----
`timescale 1ns/1ps
`include "fx_cfg.svh"

module fx_fifo #(
  parameter int W = 5,
  parameter int D = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          push;
  logic          pop;

  // Flags are registered from the next count so they never glitch
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rp_ff];

  // Occupancy
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - (AW+1)'(1);
    end
  end

  // Pointers and flags
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wp_ff     <= '0;
      rp_ff     <= '0;
      cnt_ff    <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + AW'(1);
      end
      if (pop) begin
        rp_ff <= rp_ff + AW'(1);
      end
      cnt_ff    <= nxt_cnt;
      in_ready  <= nxt_cnt != (AW+1)'(D);
      out_valid <= nxt_cnt != '0;
    end
  end

  // Storage needs no reset; valid guards every read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule

module fx_pcs import fx_pkg::*; #(
  parameter int HOLD_CYC = `FX_HOLD_US * `FX_CLK_MHZ,
  parameter int LINK_CYC = `FX_LINK_US * `FX_CLK_MHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire fx_txw_t    tx_word,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            tx_pos_ff,
  output logic            tx_neg_ff,
  input  wire logic       rx_pos,
  input  wire logic       rx_neg,
  input  wire logic [4:0] phy_address_straps,
  input  wire logic       descrambler_bypass,
  output fx_mii_t         rx_mii_ff,
  output logic            rx_stb_ff,
  output logic            link_up_ff,
  output logic            sig_detect_ff,
  output logic            desc_sync_ff,
  output logic [15:0]     false_carrier_event_counter
);
  localparam logic [79:0] TBL = `FX_4B5B;

  function automatic logic [4:0] fx_enc(input logic [3:0] n);
    fx_enc = TBL[n*5 +: 5];
  endfunction

  // Returns {valid, nibble}; a reverse search keeps one table
  function automatic logic [4:0] fx_dec(input logic [4:0] g);
    fx_dec = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (TBL[i*5 +: 5] == g) begin
        fx_dec = {1'b1, 4'(i)};
      end
    end
  endfunction

  // Pin synchronisers; first stages feed only the second
  logic [1:0] lp_m_ff, lp_s_ff;
  logic       byp_m_ff, byp_s_ff;
  logic [4:0] strap_m_ff, strap_s_ff;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lp_m_ff    <= 2'h0;
      lp_s_ff    <= 2'h0;
      byp_m_ff   <= 1'b0;
      byp_s_ff   <= 1'b0;
      strap_m_ff <= 5'h00;
      strap_s_ff <= 5'h00;
    end else begin
      lp_m_ff    <= {rx_pos, rx_neg};
      lp_s_ff    <= lp_m_ff;
      byp_m_ff   <= descrambler_bypass;
      byp_s_ff   <= byp_m_ff;
      strap_m_ff <= phy_address_straps;
      strap_s_ff <= strap_m_ff;
    end
  end

  // Straps are caught after release, once through the synchroniser
  logic [1:0] boot_ff;
  logic       seed_ld;
  assign seed_ld = boot_ff == `FX_SEED_AT;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      boot_ff <= 2'h0;
    end else if (boot_ff != 2'h3) begin
      boot_ff <= boot_ff + 2'h1;
    end
  end

  // Transmit FIFO
  fx_txw_t f_q;
  logic    f_vld, f_pop;
  fx_fifo #(.W($bits(fx_txw_t)), .D(`FX_FIFO_DEPTH)) u_txq (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (tx_word),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_q),
    .out_valid (f_vld),
    .out_ready (f_pop)
  );

  // Code-group encoder, one group per five bit times
  fx_txst_t   tst_ff, nxt_tst;
  logic [2:0] tbit_ff;
  logic [4:0] txsh_ff, nxt_code;
  logic       bnd;
  assign bnd = tbit_ff == `FX_GRP_LAST;
  always_comb begin
    nxt_tst  = tst_ff;
    nxt_code = `FX_CG_I;
    f_pop    = 1'b0;
    if (bnd) begin
      case (tst_ff)
        TX_IDLE: begin
          if (link_up_ff && f_vld) begin // [R17]
            nxt_code = `FX_CG_J;
            f_pop    = 1'b1;
            nxt_tst  = TX_K;
          end
        end
        TX_K: begin
          nxt_code = `FX_CG_K;
          f_pop    = f_vld;
          nxt_tst  = TX_DATA;
        end
        TX_DATA: begin
          if (f_vld) begin
            nxt_code = fx_enc(f_q.nib); // [R22]
            f_pop    = 1'b1;
            if (f_q.last) begin
              nxt_tst = TX_T;
            end
          end else begin
            nxt_code = `FX_CG_H; // Underrun marks the frame bad
            nxt_tst  = TX_T;
          end
        end
        TX_T: begin
          nxt_code = `FX_CG_T;
          nxt_tst  = TX_R;
        end
        TX_R: begin
          nxt_code = `FX_CG_R;
          nxt_tst  = TX_IDLE;
        end
        default: begin
          nxt_tst = TX_IDLE;
        end
      endcase
    end
  end

  // Serialiser, MSB of each group first
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tst_ff  <= TX_IDLE;
      tbit_ff <= 3'h0;
      txsh_ff <= `FX_CG_I;
    end else if (bnd) begin
      tst_ff  <= nxt_tst;
      tbit_ff <= 3'h0;
      txsh_ff <= nxt_code;
    end else begin
      tbit_ff <= tbit_ff + 3'h1;
      txsh_ff <= {txsh_ff[3:0], 1'b0};
    end
  end

  // Scrambler runs on every bit, frame or not
  logic [10:0] lf_ff;
  logic        lf_n, sbit;
  assign lf_n = lf_ff[10] ^ lf_ff[8]; // [R23]
  assign sbit = txsh_ff[4] ^ lf_n; // [R2]
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lf_ff <= `FX_LFSR_RST;
    end else if (seed_ld) begin
      lf_ff <= {strap_s_ff[4:1], `FX_SEED_FILL}; // [R3]
    end else begin
      lf_ff <= {lf_ff[9:0], lf_n}; // [R1]
    end
  end

  // NRZI then MLT-3; no binary path reaches the pins
  logic       nrzi_ff, nrzi_d_ff;
  logic [1:0] ph_ff, nxt_ph;
  assign nxt_ph = ph_ff + {1'b0, nrzi_ff ^ nrzi_d_ff};
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nrzi_ff   <= 1'b0;
      nrzi_d_ff <= 1'b0;
      ph_ff     <= 2'h0;
      tx_pos_ff <= 1'b0;
      tx_neg_ff <= 1'b0;
    end else begin
      nrzi_ff   <= nrzi_ff ^ sbit; // [R4] [R24]
      nrzi_d_ff <= nrzi_ff;
      ph_ff     <= nxt_ph;
      tx_pos_ff <= nxt_ph == 2'h1; // [R5] [R6]
      tx_neg_ff <= nxt_ph == 2'h3; // [R5] [R6]
    end
  end

  // Line decode and signal detect; short pulse trains never run long enough
  logic [1:0] lvl_d_ff;
  logic       chg, rnrzi_ff, rnrzi_d_ff, nrz;
  logic [5:0] gap_ff;
  logic [8:0] run_ff;
  assign chg = lp_s_ff != lvl_d_ff; // [R25]
  assign nrz = rnrzi_ff ^ rnrzi_d_ff; // [R24]
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lvl_d_ff      <= 2'h0;
      rnrzi_ff      <= 1'b0;
      rnrzi_d_ff    <= 1'b0;
      gap_ff        <= `FX_SD_GAP;
      run_ff        <= 9'h000;
      sig_detect_ff <= 1'b0;
    end else begin
      lvl_d_ff   <= lp_s_ff;
      rnrzi_ff   <= rnrzi_ff ^ chg;
      rnrzi_d_ff <= rnrzi_ff;
      if (chg) begin
        gap_ff <= 6'h00;
      end else if (gap_ff != `FX_SD_GAP) begin
        gap_ff <= gap_ff + 6'h01;
      end
      if (gap_ff == `FX_SD_GAP) begin
        run_ff        <= 9'h000;
        sig_detect_ff <= 1'b0;
      end else if (run_ff != `FX_SD_RUN) begin
        run_ff <= run_ff + 9'h001;
      end else begin
        sig_detect_ff <= 1'b1; // [R7]
      end
    end
  end

  // Link monitor
  logic [16:0] lcnt_ff;
  always_ff @(posedge ref_clk) begin
    if (reset || !sig_detect_ff) begin
      lcnt_ff    <= 17'h0_0000;
      link_up_ff <= 1'b0;
    end else if (lcnt_ff != 17'(LINK_CYC)) begin
      lcnt_ff <= lcnt_ff + 17'h0_0001;
    end else begin
      link_up_ff <= 1'b1; // [R17]
    end
  end

  // Descrambler trains on ~data while unsynced, since IDLE is all ones
  logic [10:0] dl_ff;
  logic [6:0]  dones_ff;
  logic [16:0] hold_ff;
  logic        dn, ud_d, ud;
  assign dn = dl_ff[10] ^ dl_ff[8];
  assign ud_d = nrz ^ dn; // [R9]
  assign ud = byp_s_ff ? nrz : ud_d; // [R14]
  always_ff @(posedge ref_clk) begin
    if (reset || (desc_sync_ff && hold_ff == 17'h0_0000)) begin
      dl_ff        <= `FX_LFSR_RST; // [R12]
      dones_ff     <= 7'h00;
      hold_ff      <= 17'(HOLD_CYC);
      desc_sync_ff <= 1'b0;
    end else begin
      dl_ff <= {dl_ff[9:0], desc_sync_ff ? dn : !nrz};
      if (!ud_d) begin
        dones_ff <= 7'h00;
      end else if (dones_ff != 7'h7f) begin
        dones_ff <= dones_ff + 7'h01;
      end
      if (!desc_sync_ff) begin
        if (ud_d && dones_ff == `FX_SYNC_BITS - 7'h01) begin
          desc_sync_ff <= 1'b1; // [R10]
          hold_ff      <= 17'(HOLD_CYC); // [R11]
        end
      // Any run past 58 ones keeps reloading, so a long idle never loses sync
      end else if (ud_d && dones_ff >= `FX_HOLD_BITS - 7'h01) begin
        hold_ff <= 17'(HOLD_CYC); // [R11]
      end else begin
        hold_ff <= hold_ff - 17'h0_0001;
      end
    end
  end

  // Aligner and decoder
  fx_rxst_t   rst_ff;
  logic [9:0] sr_ff, sr_nxt;
  logic [2:0] rph_ff;
  logic [6:0] ones_ff;
  logic [1:0] gidle_ff;
  logic [4:0] grp, dcd;
  logic       rx_on, gstb, jk_hit, bad_evt;
  assign sr_nxt = {sr_ff[8:0], ud};
  assign grp = sr_nxt[4:0]; // [R8]
  assign dcd = fx_dec(grp); // [R22]
  assign rx_on = link_up_ff && (desc_sync_ff || byp_s_ff); // [R17]
  assign gstb = rph_ff == `FX_GRP_LAST;
  assign jk_hit = sr_nxt == `FX_JK;
  assign bad_evt = rx_on && rst_ff == RX_HUNT && rph_ff == `FX_HUNT_LAST && !jk_hit;

  // Receive state machine; one strobe per delivered nibble
  always_ff @(posedge ref_clk) begin
    if (reset || !rx_on) begin
      rst_ff    <= RX_IDLE;
      sr_ff     <= 10'h3ff;
      rph_ff    <= 3'h0;
      ones_ff   <= 7'h00;
      gidle_ff  <= 2'h0;
      rx_mii_ff <= '0;
      rx_stb_ff <= 1'b0;
    end else begin
      sr_ff     <= sr_nxt;
      rx_stb_ff <= 1'b0;
      rph_ff    <= (gstb && rst_ff != RX_HUNT) ? 3'h0 : rph_ff + 3'h1;
      case (rst_ff)
        RX_IDLE: begin
          ones_ff <= !ud ? 7'h00 : (ones_ff == 7'h7f ? ones_ff : ones_ff + 7'h01);
          if (!ud && ones_ff >= `FX_IDLE_PRE) begin // [R18]
            rst_ff <= RX_HUNT;
            rph_ff <= 3'h0;
          end
        end
        RX_HUNT: begin
          if (rph_ff == `FX_HUNT_LAST) begin
            rph_ff   <= 3'h0; // [R13]
            gidle_ff <= 2'h0;
            ones_ff  <= 7'h00;
            rx_stb_ff <= 1'b1;
            if (jk_hit) begin
              rst_ff    <= RX_PRE;
              rx_mii_ff <= '{dv: 1'b1, er: 1'b0, crs: 1'b1, nib: `FX_PRE_NIB}; // [R15]
            end else begin
              rst_ff    <= RX_BAD; // [R18]
              rx_mii_ff <= '{dv: 1'b0, er: 1'b1, crs: 1'b1, nib: `FX_BAD_NIB}; // [R19]
            end
          end
        end
        RX_PRE: begin
          rst_ff    <= RX_FRAME;
          rx_stb_ff <= 1'b1; // [R15]
        end
        RX_FRAME: begin
          if (gstb) begin
            gidle_ff <= 2'h0;
            if (grp == `FX_CG_T) begin
              rst_ff <= RX_T;
            end else if (grp == `FX_CG_I) begin
              gidle_ff <= 2'h1;
              if (gidle_ff == 2'h1) begin
                rst_ff    <= RX_IDLE; // [R16]
                rx_mii_ff <= '0;
              end
            end else begin
              rx_stb_ff     <= 1'b1; // [R16]
              rx_mii_ff.nib <= dcd[3:0];
              rx_mii_ff.er  <= !dcd[4];
            end
          end
        end
        RX_T: begin
          if (gstb) begin
            if (grp == `FX_CG_R) begin
              rst_ff    <= RX_IDLE; // [R16]
              rx_mii_ff <= '0;
            end else begin
              rst_ff       <= RX_FRAME;
              rx_stb_ff    <= 1'b1;
              rx_mii_ff.er <= 1'b1;
            end
          end
        end
        RX_BAD: begin
          if (gstb) begin
            gidle_ff <= (grp == `FX_CG_I) ? 2'h1 : 2'h0;
            if (grp == `FX_CG_I && gidle_ff == 2'h1) begin
              rst_ff    <= RX_IDLE; // [R21]
              rx_mii_ff <= '0;
            end else begin
              rx_stb_ff     <= 1'b1; // [R19]
              rx_mii_ff.nib <= `FX_BAD_NIB;
              rx_mii_ff.er  <= 1'b1;
            end
          end
        end
        default: begin
          rst_ff <= RX_IDLE;
        end
      endcase
    end
  end

  // False carrier counter wraps; software samples differences
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      false_carrier_event_counter <= 16'h0000;
    end else if (bad_evt) begin
      false_carrier_event_counter <= false_carrier_event_counter + 16'h0001; // [R20]
    end
  end

  // Checks
  a_nrzi_follow: assert property (@(posedge ref_clk) disable iff (reset) // [R4]
    !reset |=> ((nrzi_ff ^ $past(nrzi_ff)) == $past(sbit)))
    else $error("NRZI did not follow scrambled bit");
  a_mlt_alternate: assert property (@(posedge ref_clk) disable iff (reset) // [R5]
    tx_pos_ff |-> !tx_neg_ff ##1 !tx_neg_ff)
    else $error("MLT-3 jumped between drive streams");
  a_sd_needs_run: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
    $rose(sig_detect_ff) |-> $past(run_ff) == `FX_SD_RUN && $past(gap_ff) != `FX_SD_GAP)
    else $error("Signal detect rose without sustained activity");
  a_sync_idle_run: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
    $rose(desc_sync_ff) |-> $past(dones_ff) == `FX_SYNC_BITS - 7'h01 && $past(ud_d))
    else $error("Sync declared without twelve idle groups");
  a_hold_restart: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    desc_sync_ff && hold_ff != 17'h0_0000 && ud_d && dones_ff == `FX_HOLD_BITS - 7'h01
    |=> hold_ff == 17'(HOLD_CYC))
    else $error("Hold timer not restarted by idle");
  a_hold_drop: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
    desc_sync_ff && hold_ff == 17'h0_0000 |=> !desc_sync_ff && dones_ff == 7'h00)
    else $error("Sync kept after hold timer expiry");
  a_link_wait: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
    $rose(link_up_ff) |-> $past(sig_detect_ff) && $past(lcnt_ff) == 17'(LINK_CYC))
    else $error("Link up before detect time");
  a_jk_preamble: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
    rx_on && rst_ff == RX_HUNT && rph_ff == `FX_HUNT_LAST && jk_hit
    |=> rx_stb_ff && rx_mii_ff.dv && rx_mii_ff.nib == `FX_PRE_NIB
    ##1 rx_stb_ff && rx_mii_ff.nib == `FX_PRE_NIB)
    else $error("J/K not replaced by preamble nibbles");
  a_bad_nibble: assert property (@(posedge ref_clk) disable iff (reset) // [R19]
    bad_evt |=> rx_mii_ff.er && rx_mii_ff.crs && rx_mii_ff.nib == `FX_BAD_NIB)
    else $error("Bad delimiter not flagged");
  a_bad_count: assert property (@(posedge ref_clk) disable iff (reset) // [R20]
    bad_evt |=> false_carrier_event_counter == $past(false_carrier_event_counter) + 16'h0001)
    else $error("False carrier count not bumped");
  a_bad_release: assert property (@(posedge ref_clk) disable iff (reset) // [R21]
    rx_on && rst_ff == RX_BAD && gstb && grp == `FX_CG_I && gidle_ff == 2'h1
    |=> !rx_mii_ff.er && !rx_mii_ff.crs)
    else $error("Error kept after two idles");
endmodule
